// ### verilog/tms_timer16.sv
/*
  16-bit timer mode sequencer top: AXI4-Lite register slave, counter
  with normal, clear-on-compare and single-slope PWM sequencing, flags
  and three compare outputs toward pins.
  Assumes one system clock; the service inputs come from an interrupt
  controller on the same clock.
*/
// The AXI4-Lite interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
module tms_timer16 import tms_pkg::*; #(
  parameter int ADDR_W = 8
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic overflow_serviced_i,
  input wire logic [CH_N-1:0] compare_serviced_i,
  input wire logic capture_serviced_i,
  output logic [CH_N-1:0] wave_output_o,
  output logic [CH_N-1:0] wave_output_oe_o
);

  // Offset decode shared by the read and the write path
  function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
    addr_ok = (a[1:0] == 2'h0) && (a <= ADDR_W'(OFS_STATUS));
  endfunction

  function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
    addr_is = (a == ADDR_W'(ofs));
  endfunction

  // Byte-lane merge of a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  // Mask of the live compare bits under a fixed TOP
  function automatic logic [15:0] res_mask(input logic [3:0] m);
    case (m)
      MODE_FAST_8: res_mask = TOP_8BIT;
      MODE_FAST_9: res_mask = TOP_9BIT;
      MODE_FAST_10: res_mask = TOP_10BIT;
      default: res_mask = CNT_MAX;
    endcase
  endfunction

  // AXI4-Lite write channel state
  logic aw_have_q;
  logic w_have_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  // AXI4-Lite read channel state
  logic rvalid_q;
  logic [1:0] rresp_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;

  // Registers and timer state
  logic [15:0] ctrl_q;
  logic [15:0] count_q;
  logic [15:0] count_d;
  logic [15:0] captop_q;
  logic [FLG_W-1:0] flags_q;
  logic [FLG_W-1:0] flags_d;
  logic block_q;

  // Decoded wires
  logic wr_fire;
  logic wr_ok;
  logic ar_fire;
  logic tick_w;
  logic [3:0] mode_w;
  logic [2:0] cs_w;
  logic [CH_N-1:0] dir_w;
  logic is_clr_cmp_w;
  logic is_fast_w;
  logic top_is_cap_w;
  logic top_is_cmpa_w;
  logic [15:0] top_w;
  logic at_top_w;
  logic top_hit_w;
  logic ovf_set_w;
  logic count_wr_w;
  logic ctrl_wr_w;
  logic captop_wr_w;
  logic flags_wr_w;
  logic [15:0] mask_w;
  logic [FLG_W-1:0] flg_set_w;
  logic [FLG_W-1:0] flg_clr_w;
  logic [CH_N-1:0] cmp_wr_w;
  logic [CH_N-1:0] match_w;
  logic [CH_N-1:0] wave_w;
  logic [15:0] active_w [CH_N];
  logic [15:0] buffer_w [CH_N];
  logic [15:0] status_w;

  // Bus handshakes: address and data are taken in either order
  assign s_axi_awready = !aw_have_q;
  assign s_axi_wready = !w_have_q;
  assign s_axi_arready = !rvalid_q;
  // A half taken while a response stands waits here until bready frees it
  assign wr_fire = aw_have_q && w_have_q && !bvalid_q;
  assign ar_fire = s_axi_arvalid && !rvalid_q;
  assign wr_ok = addr_ok(awaddr_q);

  assign ctrl_wr_w = wr_fire && addr_is(awaddr_q, OFS_CTRL);
  assign count_wr_w = wr_fire && addr_is(awaddr_q, OFS_COUNT);
  assign captop_wr_w = wr_fire && addr_is(awaddr_q, OFS_CAPTOP);
  assign flags_wr_w = wr_fire && addr_is(awaddr_q, OFS_FLAGS);

  // Control fields
  assign mode_w = ctrl_q[CTRL_MODE_POS +: 4];
  assign cs_w = ctrl_q[CTRL_CS_POS +: 3];
  assign dir_w = ctrl_q[CTRL_DIR_POS +: CH_N];

  // Sequence decode from the mode field alone
  assign is_clr_cmp_w = (mode_w == MODE_CLR_CMPA) || (mode_w == MODE_CLR_CAP);
  assign is_fast_w = (mode_w == MODE_FAST_8) || (mode_w == MODE_FAST_9) ||
                     (mode_w == MODE_FAST_10) || (mode_w == MODE_FAST_CAP) ||
                     (mode_w == MODE_FAST_CMPA);
  assign top_is_cap_w = (mode_w == MODE_CLR_CAP) || (mode_w == MODE_FAST_CAP);
  assign top_is_cmpa_w = (mode_w == MODE_CLR_CMPA) || (mode_w == MODE_FAST_CMPA);
  assign mask_w = res_mask(mode_w);

  // TOP source; capture and mode 4 compare A TOPs are read live, so a low write there is simply missed
  assign top_w = top_is_cap_w ? captop_q :
                 top_is_cmpa_w ? active_w[0] :
                 (mode_w == MODE_FAST_8) ? TOP_8BIT :
                 (mode_w == MODE_FAST_9) ? TOP_9BIT :
                 (mode_w == MODE_FAST_10) ? TOP_10BIT : CNT_MAX;
  assign at_top_w = (is_clr_cmp_w || is_fast_w) && (count_q == top_w);
  // A count write hides the TOP match in the next timer cycle as well
  assign top_hit_w = tick_w && !block_q && at_top_w;

  // Counter: written value wins over counting
  always_comb begin
    count_d = count_q;
    if (count_wr_w) begin
      count_d = merge16(count_q, wdata_q, wstrb_q);
    end else if (tick_w) begin
      if (top_hit_w) begin
        count_d = CNT_BOTTOM;
      end else begin
        count_d = count_q + 16'h0001;
      end
    end
  end

  // Overflow: wrap to zero outside PWM, arrival at TOP inside it
  assign ovf_set_w = is_fast_w ? top_hit_w :
                     (tick_w && count_q == CNT_MAX);

  always_comb begin
    flg_set_w = '0;
    flg_set_w[FLG_OVF_POS] = ovf_set_w;
    flg_set_w[FLG_CMP_POS +: CH_N] = match_w;
    flg_set_w[FLG_CAP_POS] = top_hit_w && top_is_cap_w;
  end

  // Clear by write-one or by interrupt service; a new set wins
  always_comb begin
    flg_clr_w = '0;
    if (flags_wr_w && wstrb_q[0]) begin
      flg_clr_w = wdata_q[FLG_W-1:0];
    end
    flg_clr_w[FLG_OVF_POS] = flg_clr_w[FLG_OVF_POS] || overflow_serviced_i;
    flg_clr_w[FLG_CMP_POS +: CH_N] = flg_clr_w[FLG_CMP_POS +: CH_N] | compare_serviced_i;
    flg_clr_w[FLG_CAP_POS] = flg_clr_w[FLG_CAP_POS] || capture_serviced_i;
  end
  assign flags_d = (flags_q & ~flg_clr_w) | flg_set_w;

  tms_prescaler u_presc (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .clk_sel_i(cs_w),
    .tick_o(tick_w)
  );

  genvar gi;
  generate
    for (gi = 0; gi < CH_N; gi++) begin : g_ch
      logic [15:0] cmp_data_w;
      assign cmp_wr_w[gi] = wr_fire && addr_is(awaddr_q, OFS_CMPA + 8'(4 * gi));
      // Masked at write time only, so a value written before a mode change keeps its high bits
      assign cmp_data_w = merge16(buffer_w[gi], wdata_q, wstrb_q) & mask_w;
      tms_compare_ch u_ch (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .tick_i(tick_w),
        .block_i(block_q),
        .count_i(count_q),
        .wr_i(cmp_wr_w[gi]),
        .wr_data_i(cmp_data_w),
        .pwm_i(is_fast_w),
        .top_hit_i(top_hit_w),
        .toggle_ok_i((gi == 0) && (mode_w == MODE_FAST_CMPA)),
        .action_i(ctrl_q[CTRL_ACT_POS + 2 * gi +: 2]),
        .active_o(active_w[gi]),
        .buffer_o(buffer_w[gi]),
        .match_o(match_w[gi]),
        .wave_o(wave_w[gi])
      );
    end
  endgenerate

  // The TOP bit reads zero in modes that have no TOP
  assign status_w = {12'h000, at_top_w, wave_w};

  // Read mux; compare reads return the buffered value, masked to the mode's resolution when written
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (addr_is(s_axi_araddr, OFS_CTRL)) rdata_d[15:0] = ctrl_q;
    if (addr_is(s_axi_araddr, OFS_COUNT)) rdata_d[15:0] = count_q;
    if (addr_is(s_axi_araddr, OFS_CMPA)) rdata_d[15:0] = buffer_w[0];
    if (addr_is(s_axi_araddr, OFS_CMPB)) rdata_d[15:0] = buffer_w[1];
    if (addr_is(s_axi_araddr, OFS_CMPC)) rdata_d[15:0] = buffer_w[2];
    if (addr_is(s_axi_araddr, OFS_CAPTOP)) rdata_d[15:0] = captop_q;
    if (addr_is(s_axi_araddr, OFS_FLAGS)) rdata_d[FLG_W-1:0] = flags_q;
    if (addr_is(s_axi_araddr, OFS_STATUS)) rdata_d[15:0] = status_w;
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_have_q) begin
        aw_have_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_have_q <= 1'b0;
      end
      if (s_axi_wvalid && !w_have_q) begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_have_q <= 1'b0;
      end
      if (wr_fire) begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      rvalid_q <= 1'b0;
      rresp_q <= RESP_OKAY;
      rdata_q <= 32'h0000_0000;
    // Data is captured with the address so it stands unchanged while rvalid waits
    end else if (ar_fire) begin
      rvalid_q <= 1'b1;
      rresp_q <= addr_ok(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      rdata_q <= rdata_d;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      ctrl_q <= CTRL_RESET;
      count_q <= CNT_BOTTOM;
      captop_q <= 16'h0000;
      flags_q <= '0;
      block_q <= 1'b0;
    end else begin
      count_q <= count_d;
      flags_q <= flags_d;
      if (ctrl_wr_w) begin
        ctrl_q <= merge16(ctrl_q, wdata_q, wstrb_q) & CTRL_MASK;
      end
      if (captop_wr_w) begin
        captop_q <= merge16(captop_q, wdata_q, wstrb_q);
      end
      // Held over a stopped prescaler so the first tick after a write is still blocked
      if (count_wr_w) begin
        block_q <= 1'b1;
      end else if (tick_w) begin
        block_q <= 1'b0;
      end
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;
  assign wave_output_o = wave_w;
  assign wave_output_oe_o = dir_w;

endmodule // tms_timer16

// ### inc/tms_pkg.sv
/*
  Shared constants of the 16-bit timer mode sequencer: register map,
  control field positions, waveform modes, output actions, fixed TOP
  values and AXI4-Lite response codes.
  Assumes a single system clock; the timer clock is an enable from the
  prescaler, never a clock of its own.
*/
package tms_pkg;

  localparam int CNT_W = 16;
  localparam int CH_N = 3;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_COUNT = 8'h04;
  localparam logic [7:0] OFS_CMPA = 8'h08;
  localparam logic [7:0] OFS_CMPB = 8'h0c;
  localparam logic [7:0] OFS_CMPC = 8'h10;
  localparam logic [7:0] OFS_CAPTOP = 8'h14;
  localparam logic [7:0] OFS_FLAGS = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1c;

  // Control register fields
  localparam int CTRL_MODE_POS = 0;
  localparam int CTRL_ACT_POS = 4;
  localparam int CTRL_CS_POS = 10;
  localparam int CTRL_DIR_POS = 13;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] CTRL_MASK = 16'hffff;

  // Flag register bits; compare flags sit at FLG_CMP_POS + channel
  localparam int FLG_OVF_POS = 0;
  localparam int FLG_CMP_POS = 1;
  localparam int FLG_CAP_POS = 4;
  localparam int FLG_W = 5;

  // Status register fields
  localparam int STAT_WAVE_POS = 0;
  localparam int STAT_TOP_POS = 3;

  // Waveform modes in scope
  localparam logic [3:0] MODE_NORMAL = 4'h0;
  localparam logic [3:0] MODE_CLR_CMPA = 4'h4;
  localparam logic [3:0] MODE_FAST_8 = 4'h5;
  localparam logic [3:0] MODE_FAST_9 = 4'h6;
  localparam logic [3:0] MODE_FAST_10 = 4'h7;
  localparam logic [3:0] MODE_CLR_CAP = 4'hc;
  localparam logic [3:0] MODE_FAST_CAP = 4'he;
  localparam logic [3:0] MODE_FAST_CMPA = 4'hf;

  // Output actions
  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_CLEAR = 2'h2;
  localparam logic [1:0] ACT_SET = 2'h3;

  // Counter limits and fixed TOP values
  localparam logic [15:0] CNT_MAX = 16'hffff;
  localparam logic [15:0] CNT_BOTTOM = 16'h0000;
  localparam logic [15:0] TOP_8BIT = 16'h00ff;
  localparam logic [15:0] TOP_9BIT = 16'h01ff;
  localparam logic [15:0] TOP_10BIT = 16'h03ff;

  // Prescaler select codes and divide counts
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_DIV1 = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [9:0] DIV8_LAST = 10'h007;
  localparam logic [9:0] DIV64_LAST = 10'h03f;
  localparam logic [9:0] DIV256_LAST = 10'h0ff;
  localparam logic [9:0] DIV1024_LAST = 10'h3ff;

  // AXI4-Lite responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ### verilog/tms_prescaler.sv
/*
  Prescaler for the timer: turns the system clock into a one-cycle
  timer tick every 1, 8, 64, 256 or 1024 clocks, or none when stopped.
  Assumes the select code comes from logic on the same clock.
*/
`timescale 1ns/100ps
module tms_prescaler import tms_pkg::*; (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic [2:0] clk_sel_i,
  output logic tick_o
);

  logic [9:0] div_q;
  logic [9:0] div_d;
  logic [9:0] last_w;
  logic run_w;
  logic wrap_w;

  assign last_w = (clk_sel_i == CS_DIV8) ? DIV8_LAST :
                  (clk_sel_i == CS_DIV64) ? DIV64_LAST :
                  (clk_sel_i == CS_DIV256) ? DIV256_LAST :
                  (clk_sel_i == CS_DIV1024) ? DIV1024_LAST : 10'h000;
  assign run_w = (clk_sel_i != CS_STOP) && (clk_sel_i <= CS_DIV1024);
  // A select change that lowers the limit below the count still ends the period
  assign wrap_w = div_q >= last_w;
  assign div_d = (!run_w || wrap_w) ? 10'h000 : div_q + 10'h001;
  assign tick_o = run_w && wrap_w;

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      div_q <= 10'h000;
    end else begin
      div_q <= div_d;
    end
  end

endmodule // tms_prescaler

// ### verilog/tms_compare_ch.sv
/*
  One compare channel: buffered compare value, match detection and the
  output waveform state.
  Assumes the parent gives it timer ticks, the TOP event and the mode
  decode on the same clock.
*/
`timescale 1ns/100ps
module tms_compare_ch import tms_pkg::*; (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic tick_i,
  input wire logic block_i,
  input wire logic [15:0] count_i,
  input wire logic wr_i,
  input wire logic [15:0] wr_data_i,
  input wire logic pwm_i,
  input wire logic top_hit_i,
  input wire logic toggle_ok_i,
  input wire logic [1:0] action_i,
  output logic [15:0] active_o,
  output logic [15:0] buffer_o,
  output logic match_o,
  output logic wave_o
);

  logic [15:0] active_q;
  logic [15:0] buf_q;
  logic wave_q;
  logic wave_d;
  logic upd_w;

  assign match_o = tick_i && !block_i && (count_i == active_q);
  // Buffered copy lands with the counter clear at TOP
  assign upd_w = pwm_i && top_hit_i;

  always_comb begin
    wave_d = wave_q;
    if (pwm_i) begin
      if (top_hit_i && action_i == ACT_CLEAR) wave_d = 1'b0;
      if (top_hit_i && action_i == ACT_SET) wave_d = 1'b1;
      // Match beats TOP so a compare equal to TOP gives a steady level
      if (match_o && action_i == ACT_CLEAR) wave_d = 1'b1;
      if (match_o && action_i == ACT_SET) wave_d = 1'b0;
      if (match_o && action_i == ACT_TOGGLE && toggle_ok_i) wave_d = !wave_q;
    end else if (match_o) begin
      case (action_i)
        ACT_TOGGLE: wave_d = !wave_q;
        ACT_CLEAR: wave_d = 1'b0;
        ACT_SET: wave_d = 1'b1;
        default: wave_d = wave_q;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      buf_q <= 16'h0000;
      active_q <= 16'h0000;
      wave_q <= 1'b0;
    end else begin
      wave_q <= wave_d;
      if (wr_i) begin
        buf_q <= wr_data_i;
      end
      if (wr_i && !pwm_i) begin
        active_q <= wr_data_i;
      end else if (upd_w) begin
        active_q <= buf_q;
      end
    end
  end

  assign active_o = active_q;
  assign buffer_o = buf_q;
  assign wave_o = wave_q;

endmodule // tms_compare_ch

// ### sim/tms_pin_load.sv
/*
  Load on the three compare output pins, with a weak pull-down.
  Assumes the pad drives only while its direction bit is set.
*/
`timescale 1ns/100ps
module tms_pin_load import tms_pkg::*; (
  input wire logic [CH_N-1:0] drive_i,
  input wire logic [CH_N-1:0] en_i,
  output logic [CH_N-1:0] level_o
);
  // Released pins fall to the pull-down level, never the last driven value
  assign level_o = drive_i & en_i;
endmodule // tms_pin_load

// ### sim/tms_timer16_sva.sv
/*
  Checker for the timer top: register bus handshakes and pin direction.
  Assumes it is bound to tms_timer16 and sees only its ports.
*/
`timescale 1ns/100ps
module tms_timer16_sva import tms_pkg::*; (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [CH_N-1:0] wave_output_oe_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_write_answer: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  a_read_answer: assert property (rd_taken |=> s_axi_rvalid)
    else $error("read response late");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read data dropped");
  a_resp_busy: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response not released");
  a_ready_back: assert property (s_axi_bvalid && s_axi_bready |=>
    s_axi_awready && s_axi_wready)
    else $error("write channels not reopened");
  a_slverr_zero: assert property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR |->
    s_axi_rdata == 32'h0)
    else $error("refused read carries data");
  a_dir_by_write: assert property ($past(rst_n_i) && !$stable(wave_output_oe_o) |->
    $rose(s_axi_bvalid))
    else $error("pin direction changed without write");
endmodule // tms_timer16_sva

bind tms_timer16 tms_timer16_sva chk_u (.clk_sys_i, .rst_n_i, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready, .wave_output_oe_o);

// ### sim/timer16_mode_sequencer_bench.sv
/*
  Self-checking bench for the timer: register bus tasks and mode scenarios.
  Assumes divide-by-one ticks, except the mode 15 scenario, which divides by eight.
*/
`timescale 1ns/100ps
module timer16_mode_sequencer_bench import tms_pkg::*;;
  logic clk_sys_i, rst_n_i;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_q;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, overflow_serviced_i, capture_serviced_i;
  logic [1:0] s_axi_bresp, s_axi_rresp, last_resp;
  logic [CH_N-1:0] compare_serviced_i, wave_output_o, wave_output_oe_o, pin;
  int fail_count, comparisons, cycles;

  tms_timer16 #(.ADDR_W(8)) dut_u (.clk_sys_i, .rst_n_i, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .overflow_serviced_i, .compare_serviced_i,
    .capture_serviced_i, .wave_output_o, .wave_output_oe_o);
  tms_pin_load load_u (.drive_i(wave_output_o), .en_i(wave_output_oe_o), .level_o(pin));

  initial begin
    clk_sys_i = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end

  // Longest run is three fixed-TOP periods of 1024 plus bus traffic
  always @(posedge clk_sys_i) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      fail_count++;
      results();
    end
  end

  task results;
    if (fail_count == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task cmp(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // A late ready keeps the response standing for a few cycles
  task wr(input logic [7:0] a, input logic [31:0] d, input int late = 0);
    int k;
    @(posedge clk_sys_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= (late == 0);
    k = 0;
    do begin
      @(posedge clk_sys_i);
      k++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (k == late) s_axi_bready <= 1'b1;
    end while (!(s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1));
    s_axi_bready <= 1'b0;
    last_resp = s_axi_bresp;
  endtask

  task rd(input logic [7:0] a, input int late = 0);
    int k;
    @(posedge clk_sys_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= (late == 0);
    k = 0;
    do begin
      @(posedge clk_sys_i);
      k++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (k == late) s_axi_rready <= 1'b1;
    end while (!(s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1));
    s_axi_rready <= 1'b0;
    rd_q = s_axi_rdata;
    last_resp = s_axi_rresp;
  endtask

  task rdm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    rd(a);
    cmp(rd_q & m, e);
  endtask

  // Skips one whole pulse, and any pulse already under way, so a period still using old buffered values is ignored
  task meas(input int ch, input int e);
    int n;
    repeat (2) begin
      do @(posedge clk_sys_i); while (pin[ch] !== 1'b0);
      do @(posedge clk_sys_i); while (pin[ch] !== 1'b1);
    end
    n = 0;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (pin[ch] === 1'b1);
    cmp(n, e);
  endtask

  task t_ctc;
    logic c;
    int n;
    wr(OFS_CMPA, 32'h0);
    wr(OFS_CTRL, 32'h2414);
    meas(0, 1);
    wr(OFS_CMPA, 32'h3);
    meas(0, 4);
    rdm(OFS_FLAGS, 32'h2, 32'h2);
    wr(OFS_CTRL, 32'h2404);
    c = pin[0];
    n = 0;
    repeat (20) begin
      @(posedge clk_sys_i);
      if (pin[0] !== c) n++;
    end
    cmp(n, 0);
    wr(OFS_CAPTOP, 32'h5);
    wr(OFS_CTRL, 32'h241c);
    meas(0, 6);
    rdm(OFS_FLAGS, 32'h10, 32'h10);
    wr(OFS_CTRL, 32'h041c);
    repeat (3) @(posedge clk_sys_i);
    cmp({wave_output_oe_o[0], pin[0]}, 0);
  endtask

  task t_normal;
    wr(OFS_CTRL, 32'h0);
    wr(OFS_COUNT, 32'hfffa);
    wr(OFS_FLAGS, 32'h1f);
    rdm(OFS_FLAGS, 32'h1, 32'h0);
    wr(OFS_CTRL, 32'h0410);
    repeat (20) @(posedge clk_sys_i);
    wr(OFS_CTRL, 32'h0);
    rdm(OFS_FLAGS, 32'h1, 32'h1);
    rd(OFS_COUNT);
    cmp(rd_q > 3 && rd_q < 64, 1);
    @(posedge clk_sys_i);
    overflow_serviced_i <= 1'b1;
    compare_serviced_i <= 3'h7;
    capture_serviced_i <= 1'b1;
    @(posedge clk_sys_i);
    overflow_serviced_i <= 1'b0;
    compare_serviced_i <= 3'h0;
    capture_serviced_i <= 1'b0;
    rdm(OFS_FLAGS, 32'h1f, 32'h0);
  endtask

  task t_wrap;
    wr(OFS_CTRL, 32'h000c);
    wr(OFS_COUNT, 32'hfff0);
    wr(OFS_FLAGS, 32'h1f);
    wr(OFS_CTRL, 32'h040c);
    repeat (40) @(posedge clk_sys_i);
    wr(OFS_CTRL, 32'h000c);
    rdm(OFS_FLAGS, 32'h11, 32'h11);
    rd(OFS_COUNT);
    cmp(rd_q <= 5, 1);
  endtask

  task t_pwm;
    wr(OFS_CAPTOP, 32'h9);
    wr(OFS_CMPB, 32'h3);
    wr(OFS_COUNT, 32'h0);
    wr(OFS_CTRL, 32'h448e);
    meas(1, 6);
    wr(OFS_CTRL, 32'h44ce);
    meas(1, 4);
    wr(OFS_FLAGS, 32'h1f);
    repeat (12) @(posedge clk_sys_i);
    rdm(OFS_FLAGS, 32'h15, 32'h15);
  endtask

  task t_fixed;
    logic [15:0] t;
    for (int i = 0; i < 3; i++) begin
      t = (i == 0) ? TOP_8BIT : (i == 1) ? TOP_9BIT : TOP_10BIT;
      wr(OFS_CTRL, 32'(MODE_FAST_8) + i);
      wr(OFS_CMPB, 32'hffff);
      rdm(OFS_CMPB, 32'hffff, 32'(t));
      wr(OFS_CMPB, 32'(t) - 15);
      wr(OFS_COUNT, 32'h0);
      wr(OFS_CTRL, 32'h44c0 + 32'(MODE_FAST_8) + i);
      meas(1, int'(t) - 14);
    end
  endtask

  // Mode 15 toggle of output A at divide-by-eight, TOP taken from compare A's active copy, reloaded from the buffer at TOP
  task t_fast15;
    wr(OFS_CTRL, 32'h000f);
    wr(OFS_CMPA, 32'h4);
    wr(OFS_COUNT, 32'h0);
    wr(OFS_CTRL, 32'h281f);
    meas(0, 40);
  endtask

  task t_bad;
    wr(8'h20, 32'h1, 3);
    cmp(last_resp, RESP_SLVERR);
    rd(8'h20, 3);
    cmp(rd_q, 32'h0);
    cmp(last_resp, RESP_SLVERR);
  endtask

  initial begin
    rst_n_i = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'h3;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = 8'h00;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    overflow_serviced_i = 1'b0;
    compare_serviced_i = 3'h0;
    capture_serviced_i = 1'b0;
    repeat (3) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    t_ctc;
    t_normal;
    t_wrap;
    t_pwm;
    t_fixed;
    t_fast15;
    t_bad;
    results;
  end
endmodule // timer16_mode_sequencer_bench
